// [rtl/sfc_core.sv]
// command sequencer of a serial flash: status access and array reads
// assumes host pins are asynchronous and sampled here; the array sits
// outside behind a one-cycle read port; program/erase run elsewhere
//
// Summary of operation
// R01: write disable 04h clears write enable latch
// R02: latch cleared when write operations complete
// R03: write disable cancels volatile status enable
// R04: 05h/35h shift status byte out MSB first
// R05: status reads accepted even while busy
// R06: status byte repeats until chip select rises
// R07: only listed status bits are writable
// R08: lock bits never return from one to zero; soft_reset may clear volatile ones
// R09: non-volatile status write needs latch set
// R10: volatile status write leaves latch unchanged
// R11: reset reloads volatile copies from stored values
// R12: non-volatile write busy for status_write_time
// R13: volatile write applied promptly, busy stays zero
// R14: quad_enable frozen in four-wire command mode
// R15: 01h writes one or two registers by length
// R16: read 03h: opcode, 24-bit address, data out
// R17: array address increments per byte while clocked
// R18: array reads ignored while busy
// R19: fast read inserts eight dummy clocks
// R20: four-wire fast read dummies 2/4/6/8, default 2
// R21: dual output read drives two lines outside four-wire mode
// R22: host releases io_line_0 before dual data
// R23: dual byte: line1 odd bits, line0 even
// R24: write enable 06h sets the latch
// R25: volatile enable 50h does not set latch
// R26: chip select high aborts decode
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`include "sfc_map.svh"
module sfc_core #(
  parameter int unsigned TW_NS = `SFC_TW_NS
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sck,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe,
  input  wire logic        op_busy,
  input  wire logic        op_done,
  input  wire logic        soft_reset,
  output logic      [23:0] mem_addr,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);
  import sfc_pkg::*;

  localparam int unsigned TW_CYC = (TW_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS;

  sfc_state_s q;
  sfc_state_s d;
  logic [5:0] pin_s;
  logic       cs_s;
  logic       sck_s;
  logic [3:0] io_s;
  logic       four_wire_command_mode;
  logic       busy;
  logic [7:0] sr1_w;
  logic [7:0] sr2_w;
  logic [5:0] kin;
  logic       ev_rise;
  logic       ev_fall;
  logic       ev_exec;
  logic       len_ok;
  logic       nv_ok;
  logic       vol_ok;
  logic [7:0] new1;
  logic [7:0] new2;
  logic [7:0] mask2;
  logic [7:0] byte_n;

  // ***********************************
  // helpers
  // ***********************************
  function automatic logic [23:0] shin(logic [23:0] s, logic [3:0] b, logic quad);
    return quad ? {s[19:0], b} : {s[22:0], b[0]};
  endfunction

  // lock bits stay set whatever the incoming data says
  function automatic logic [7:0] merge(logic [7:0] old, logic [7:0] din,
                                       logic [7:0] wm, logic [7:0] otp);
    return (old & ~wm) | (din & wm) | (old & otp); // see R07 see R08
  endfunction

  function automatic logic is_wsr(logic [7:0] op);
    return op == `SFC_OP_WRSR1 || op == `SFC_OP_WRSR2 || op == `SFC_OP_WRSR3;
  endfunction

  // ***********************************
  // pin sampling and events
  // ***********************************
  sfc_sync #(
    .W (6)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .din     ({spi_cs_n, spi_sck, io_in}),
    .dout    (pin_s)
  );

  assign cs_s    = pin_s[5];
  assign sck_s   = pin_s[4];
  assign io_s    = pin_s[3:0];
  assign four_wire_command_mode     = q.ctrl[`SFC_CTRL_QPI];
  assign busy    = q.wsr_busy | op_busy;
  assign sr1_w   = {q.vol1[7:2], q.write_enable_latch, busy};
  assign sr2_w   = {1'b0, q.vol2[6:0]};
  assign kin     = four_wire_command_mode ? 6'h04 : 6'h01;
  assign ev_rise = clk_en && !cs_s && sck_s && !q.sck_p;
  assign ev_fall = clk_en && !cs_s && !sck_s && q.sck_p;
  assign ev_exec = clk_en && cs_s && !q.cs_p;

  // ***********************************
  // status write staging
  // ***********************************
  // a bit count other than 8, or 16 for 01h, discards the write
  assign len_ok = q.cnt == `SFC_BYTE_BITS ||
                  (q.cnt == `SFC_WORD_BITS && q.op == `SFC_OP_WRSR1); // see R15
  assign nv_ok  = ev_exec && q.pend && is_wsr(q.op) && len_ok && !busy &&
                  !q.vol_en && q.write_enable_latch; // see R09
  assign vol_ok = ev_exec && q.pend && is_wsr(q.op) && len_ok && !busy &&
                  q.vol_en;
  assign mask2  = four_wire_command_mode ? (`SFC_SR2_WMASK & ~`SFC_SR2_QE) : `SFC_SR2_WMASK; // see R14

  always_comb begin
    new1 = q.vol1;
    new2 = q.vol2;
    if (q.op == `SFC_OP_WRSR1) begin
      new1 = merge(q.vol1, (q.cnt == `SFC_WORD_BITS) ? q.sh[15:8] : q.sh[7:0],
                   `SFC_SR1_WMASK, 8'h00);
      if (q.cnt == `SFC_WORD_BITS) begin
        new2 = merge(q.vol2, q.sh[7:0], mask2, `SFC_SR2_OTP); // see R15
      end
    end else if (q.op == `SFC_OP_WRSR2) begin
      new2 = merge(q.vol2, q.sh[7:0], mask2, `SFC_SR2_OTP);
    end
  end

  // ***********************************
  // sequencer
  // ***********************************
  always_comb begin
    d      = q;
    byte_n = q.obyte;
    if (clk_en) begin
      d.sck_p   = sck_s;
      d.cs_p    = cs_s;
      d.rd_data = 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `SFC_REG_CTRL: d.rd_data = {29'h0000_0000, q.ctrl};
          `SFC_REG_STAT: d.rd_data = {16'h0000, sr2_w, sr1_w};
          default:       d.rd_data = 32'h0000_0000;
        endcase
      end
      if (reg_wr && reg_addr == `SFC_REG_CTRL) begin
        d.ctrl = reg_wdata[2:0];
      end
      if (op_done) begin
        d.write_enable_latch = 1'b0; // see R02
      end
      if (q.wsr_busy) begin
        d.tmr = q.tmr - 32'h0000_0001;
        if (q.tmr == 32'h0000_0001) begin
          d.wsr_busy = 1'b0; // see R12
          d.write_enable_latch      = 1'b0; // see R02
          d.nv1      = q.stage1;
          d.nv2      = q.stage2;
          d.vol1     = q.stage1;
          d.vol2     = q.stage2;
        end
      end
      if (soft_reset) begin
        d.vol1   = d.nv1; // see R11
        d.vol2   = d.nv2;
        d.vol_en = 1'b0;
      end
      if (cs_s) begin
        // deselect drops any half-taken command and the bus
        d.phase = SFC_CMD; // see R26
        d.cnt   = 6'h00;
        d.io_oe = 4'h0;
        if (ev_exec) begin
          d.pend = 1'b0;
          if (q.pend) begin
            case (q.op)
              `SFC_OP_WRDI: begin
                d.write_enable_latch    = 1'b0; // see R01
                d.vol_en = 1'b0; // see R03
              end
              `SFC_OP_WREN:  d.write_enable_latch    = 1'b1; // see R24
              `SFC_OP_VWREN: d.vol_en = 1'b1; // see R25
              default: begin
                if (vol_ok) begin
                  d.vol1   = new1; // see R10 see R13
                  d.vol2   = new2;
                  d.vol_en = 1'b0;
                end else if (nv_ok) begin
                  d.stage1   = new1;
                  d.stage2   = new2;
                  d.wsr_busy = 1'b1; // see R12
                  d.tmr      = 32'(TW_CYC);
                end
              end
            endcase
          end
        end
      end else if (ev_rise) begin
        case (q.phase)
          SFC_CMD: begin
            d.sh  = shin(q.sh, io_s, four_wire_command_mode);
            d.cnt = q.cnt + kin;
            if (d.cnt == `SFC_BYTE_BITS) begin
              d.op    = d.sh[7:0];
              d.cnt   = 6'h00;
              d.obits = 4'h0;
              d.kout  = four_wire_command_mode ? 3'h4 : 3'h1;
              case (d.sh[7:0])
                `SFC_OP_RDSR1, `SFC_OP_RDSR2: begin
                  d.phase    = SFC_OUT; // see R04 see R05
                  d.src_stat = 1'b1;
                  d.sel2     = d.sh[7:0] == `SFC_OP_RDSR2;
                end
                `SFC_OP_WRSR1, `SFC_OP_WRSR2, `SFC_OP_WRSR3: begin
                  d.phase = SFC_WDAT;
                  d.pend  = 1'b1;
                end
                `SFC_OP_WRDI, `SFC_OP_WREN, `SFC_OP_VWREN: begin
                  d.phase = SFC_IGN;
                  d.pend  = 1'b1;
                end
                `SFC_OP_READ, `SFC_OP_FREAD, `SFC_OP_DREAD: begin
                  d.phase    = busy ? SFC_IGN : SFC_ADDR; // see R18
                  d.src_stat = 1'b0;
                  if (!four_wire_command_mode && d.sh[7:0] == `SFC_OP_DREAD) begin
                    d.kout = 3'h2; // see R21
                  end
                end
                default: d.phase = SFC_IGN;
              endcase
            end
          end
          SFC_ADDR: begin
            d.sh  = shin(q.sh, io_s, four_wire_command_mode);
            d.cnt = q.cnt + kin;
            if (d.cnt == `SFC_ADDR_BITS) begin
              d.addr  = d.sh; // see R16
              d.phase = (q.op == `SFC_OP_READ) ? SFC_OUT : SFC_DUM;
              d.dcnt  = `SFC_SPI_DUMMY; // see R19
              if (four_wire_command_mode && q.op == `SFC_OP_FREAD) begin
                d.dcnt = {1'b0, q.ctrl[`SFC_CTRL_DUM], 1'b0} + `SFC_QPI_DUM0; // see R20
              end
            end
          end
          SFC_DUM: begin
            d.dcnt = q.dcnt - 4'h1;
            if (q.dcnt == 4'h1) begin
              d.phase = SFC_OUT;
            end
          end
          SFC_WDAT: begin
            if (q.cnt <= `SFC_WORD_BITS) begin
              d.sh  = shin(q.sh, io_s, four_wire_command_mode);
              d.cnt = q.cnt + kin;
            end
          end
          SFC_IGN: d.pend = 1'b0;
          default: d.phase = q.phase;
        endcase
      end else if (ev_fall && q.phase == SFC_OUT) begin
        if (q.obits == 4'h0) begin
          // status is resampled each byte so busy polling sees live state
          if (q.src_stat) begin
            byte_n = q.sel2 ? sr2_w : sr1_w; // see R06
          end else begin
            byte_n = mem_rdata;
            d.addr = q.addr + 24'h00_0001; // see R17
          end
        end
        case (q.kout)
          3'h4: begin
            d.io_out = byte_n[7:4];
            d.io_oe  = 4'hF;
          end
          3'h2: begin
            d.io_out = {2'h0, byte_n[7:6]}; // see R23
            d.io_oe  = 4'h3; // see R22
          end
          default: begin
            d.io_out = {2'h0, byte_n[7], 1'b0}; // see R04
            d.io_oe  = 4'h2;
          end
        endcase
        d.obyte = 8'(byte_n << q.kout);
        d.obits = ((q.obits == 4'h0) ? 4'h8 : q.obits) - {1'b0, q.kout};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q      <= '0;
      q.ctrl <= `SFC_CTRL_RST;
      q.nv1  <= `SFC_NV1_RST; // see R11
      q.nv2  <= `SFC_NV2_RST;
      q.vol1 <= `SFC_NV1_RST;
      q.vol2 <= `SFC_NV2_RST;
      q.sck_p <= 1'b1;
      q.cs_p  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign io_out    = q.io_out;
  assign io_oe     = q.io_oe;
  assign mem_addr  = q.addr;
  assign reg_rdata = q.rd_data;

  // ***********************************
  // checks
  // ***********************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_nv_start;
    nv_ok && !soft_reset && !op_done;
  endsequence

  sequence s_wrdi_exec;
    ev_exec && q.pend && q.op == `SFC_OP_WRDI;
  endsequence

  a_wrdi_clears_wel: assert property (s_wrdi_exec |=> !q.write_enable_latch) // see R01
    else $error("write disable left latch set");
  a_wrdi_kills_vol: assert property (s_wrdi_exec |=> !q.vol_en) // see R03
    else $error("write disable left volatile enable");
  a_nv_busy_wel: assert property (s_nv_start |=> q.wsr_busy && sr1_w[0] && q.write_enable_latch) // see R12
    else $error("status write cycle not busy");
  a_vol_no_busy: assert property (vol_ok && !op_done |=> // see R13
      !q.wsr_busy && q.write_enable_latch == $past(q.write_enable_latch))
    else $error("volatile write touched busy or latch");
  a_otp_sticky: assert property (!soft_reset |=>
      ((($past(q.vol2) & `SFC_SR2_OTP) & ~q.vol2) == 8'h00)) // see R08
    else $error("lock bit returned to zero");
  a_read_busy_ign: assert property (ev_rise && q.phase == SFC_CMD && busy &&
      d.sh[7:0] == `SFC_OP_READ && q.cnt + kin == `SFC_BYTE_BITS |=>
      q.phase == SFC_IGN) // see R18
    else $error("array read taken while busy");
  a_cs_high_oe: assert property (clk_en && cs_s |=> q.io_oe == 4'h0 && q.phase == SFC_CMD) // see R26
    else $error("outputs driven while deselected");
  a_dual_lanes: assert property (ev_fall && q.phase == SFC_OUT && q.kout == 3'h2 |=> // see R23
      q.io_oe == 4'h3 && q.io_out[1:0] ==
      $past(q.obits == 4'h0 ? mem_rdata[7:6] : q.obyte[7:6]))
    else $error("dual lane order wrong");
  a_qe_frozen: assert property (vol_ok && four_wire_command_mode |=> q.vol2[1] == $past(q.vol2[1])) // see R14
    else $error("quad enable changed in four-wire mode");
endmodule

// [rtl/sfc_map.svh]
// constants for the serial flash command sequencer: opcodes, status bit
// layout, register map and timing; assumes inclusion by bare name
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH

// ***********************************
// opcodes
// ***********************************
`define SFC_OP_WRDI   8'h04
`define SFC_OP_WREN   8'h06
`define SFC_OP_VWREN  8'h50
`define SFC_OP_RDSR1  8'h05
`define SFC_OP_RDSR2  8'h35
`define SFC_OP_WRSR1  8'h01
`define SFC_OP_WRSR2  8'h31
`define SFC_OP_WRSR3  8'h11
`define SFC_OP_READ   8'h03
`define SFC_OP_FREAD  8'h0B
`define SFC_OP_DREAD  8'h3B

// ***********************************
// status layout
// ***********************************
`define SFC_SR1_WMASK 8'hFC
`define SFC_SR2_WMASK 8'h7F
`define SFC_SR2_OTP   8'h3D
`define SFC_SR2_QE    8'h02
`define SFC_NV1_RST   8'h00
`define SFC_NV2_RST   8'h00

// ***********************************
// frame bit counts
// ***********************************
`define SFC_BYTE_BITS 6'h08
`define SFC_WORD_BITS 6'h10
`define SFC_ADDR_BITS 6'h18
`define SFC_SPI_DUMMY 4'h8
`define SFC_QPI_DUM0  4'h2

// ***********************************
// register map
// ***********************************
`define SFC_REG_CTRL  2'h0
`define SFC_REG_STAT  2'h1
`define SFC_CTRL_QPI  0
`define SFC_CTRL_DUM  2:1
`define SFC_CTRL_RST  3'h0

// ***********************************
// timing
// ***********************************
`define SFC_CLK_NS    20
`define SFC_TW_NS     10000000

`endif

// [rtl/sfc_pkg.sv]
// types of the serial flash command sequencer
// assumes sfc_map.svh supplies all numeric constants
package sfc_pkg;

  typedef enum logic [2:0] {
    SFC_CMD,
    SFC_ADDR,
    SFC_DUM,
    SFC_WDAT,
    SFC_OUT,
    SFC_IGN
  } sfc_phase_e;

  typedef struct packed {
    sfc_phase_e  phase;
    logic        sck_p;
    logic        cs_p;
    logic [5:0]  cnt;
    logic [23:0] sh;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [3:0]  dcnt;
    logic [7:0]  obyte;
    logic [3:0]  obits;
    logic [2:0]  kout;
    logic        src_stat;
    logic        sel2;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic        pend;
    logic        write_enable_latch;
    logic        vol_en;
    logic [7:0]  vol1;
    logic [7:0]  vol2;
    logic [7:0]  nv1;
    logic [7:0]  nv2;
    logic [7:0]  stage1;
    logic [7:0]  stage2;
    logic        wsr_busy;
    logic [31:0] tmr;
    logic [2:0]  ctrl;
    logic [31:0] rd_data;
  } sfc_state_s;

endpackage

// [rtl/sfc_sync.sv]
// two-flop synchroniser for the flash pins
// assumes inputs are asynchronous to sys_clk; idles high after reset
`timescale 1ns/1ps
module sfc_sync #(
  parameter int W = 6
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [1:0][W-1:0] st_q;
  logic [1:0][W-1:0] st_d;

  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      st_d[0] = din;
      st_d[1] = st_q[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q[1];
endmodule

// [test/serial_flash_status_and_read_cmds_tb_top.sv]
// self-checking bench of the flash command sequencer
// assumes sfc_host drives the link and a byte function models the array
`timescale 1ns/1ps
`include "sfc_map.svh"
module serial_flash_status_and_read_cmds_tb_top;
  import sfc_pkg::*;
  logic        sys_clk, rst_n, spi_cs_n, spi_sck, op_busy, op_done, soft_reset;
  logic        reg_wr, reg_rd, write_enable_latch, clk_en;
  logic [3:0]  io_in, io_out, io_oe;
  logic [23:0] mem_addr;
  logic [7:0]  mem_rdata, v1, v2, n1, n2;
  logic [1:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int          miscompares, n_compared, seed;

  // ***********************************
  // models and helpers
  // ***********************************
  function automatic logic [7:0] ebyte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
  endfunction
  function automatic logic [7:0] wm(input logic [7:0] o, n, m, p);
    return (o & ~m) | (n & m) | (o & p);
  endfunction
  function automatic logic [7:0] st(input logic bz);
    return {v1[7:2], write_enable_latch, bz};
  endfunction
  assign mem_rdata = ebyte(mem_addr);

  sfc_host host (.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .io_in(io_in), .io_out(io_out),
                 .io_oe(io_oe));
  sfc_core #(.TW_NS(2000)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .op_busy(op_busy), .op_done(op_done), .soft_reset(soft_reset), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rwr(input logic [1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rrd(input logic [1:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic pulse(input int k);
    @(posedge sys_clk);
    if (k == 1) op_done <= 1'b1;
    else soft_reset <= 1'b1;
    @(posedge sys_clk);
    op_done <= 1'b0;
    soft_reset <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] op, input logic [15:0] d, input int n);
    host.sel();
    host.tx(op, 8, 1);
    if (n > 0) host.tx(d, n, 1);
    host.desel();
  endtask
  task automatic rd_stat(input logic [7:0] op, input logic [7:0] e, input int n);
    logic [7:0] b;
    host.sel();
    host.tx(op, 8, 1);
    repeat (n) begin
      host.rx(1, b);
      chk(b, e);
    end
    host.desel();
  endtask
  task automatic rd_arr(input logic [7:0] op, input logic [23:0] a, input int nd, w, nb);
    logic [7:0] b;
    int c;
    c = (w == 4) ? 4 : 1;
    host.sel();
    host.tx(op, 8 / c, c);
    host.tx(a, 24 / c, c);
    host.dum(nd);
    for (int i = 0; i < nb; i++) begin
      host.rx(w, b);
      chk(b, ebyte(a + 24'(i)));
    end
    host.desel();
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ***********************************
  // clock, watchdog, scenarios
  // ***********************************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #1500000;
    miscompares++;
    summarize();
  end
  initial begin
    logic [31:0] r;
    logic [7:0]  d1, d2, b;
    {rst_n, op_busy, op_done, soft_reset, reg_wr, reg_rd, reg_addr} = '0;
    {reg_wdata, v1, v2, n1, n2, write_enable_latch, miscompares, n_compared} = '0;
    clk_en = 1'b1;
    seed = 32'hc0ef;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rrd(`SFC_REG_CTRL, r);
    chk(r, 32'h0);
    rrd(`SFC_REG_STAT, r);
    chk(r, 32'h0);
    rrd(2'h3, r);
    chk(r, 32'h0);
    // an opcode cut short by chip select must not act
    host.sel();
    host.tx(`SFC_OP_WREN, 7, 1);
    host.desel();
    rd_stat(`SFC_OP_RDSR1, st(1'b0), 1);
    wr(`SFC_OP_WREN, 16'h0, 0);
    write_enable_latch = 1'b1;
    rd_stat(`SFC_OP_RDSR1, st(1'b0), 3);
    wr(`SFC_OP_WRDI, 16'h0, 0);
    write_enable_latch = 1'b0;
    rd_stat(`SFC_OP_RDSR1, st(1'b0), 2);
    repeat (3) begin
      d1 = 8'($random(seed)) & 8'h7C;
      wr(`SFC_OP_VWREN, 16'h0, 0);
      wr(`SFC_OP_WRSR1, {8'h00, d1}, 8);
      v1 = wm(v1, d1, `SFC_SR1_WMASK, 8'h00);
      rd_stat(`SFC_OP_RDSR1, st(1'b0), 1);
    end
    wr(`SFC_OP_VWREN, 16'h0, 0);
    wr(`SFC_OP_WRDI, 16'h0, 0);
    wr(`SFC_OP_WRSR1, {8'h00, ~v1 & 8'h7C}, 8);
    rd_stat(`SFC_OP_RDSR1, st(1'b0), 1);
    d1 = 8'($random(seed)) & 8'h7C;
    d2 = (8'($random(seed)) & 8'h7C) | 8'h04;
    wr(`SFC_OP_WREN, 16'h0, 0);
    wr(`SFC_OP_WRSR1, {d1, d2}, 16);
    rrd(`SFC_REG_STAT, r);
    chk(r[1:0], 2'b11);
    repeat (150) @(posedge sys_clk);
    n1 = wm(n1, d1, `SFC_SR1_WMASK, 8'h00);
    n2 = wm(n2, d2, `SFC_SR2_WMASK, `SFC_SR2_OTP);
    v1 = n1;
    v2 = n2;
    write_enable_latch = 1'b0;
    rd_stat(`SFC_OP_RDSR1, st(1'b0), 1);
    rd_stat(`SFC_OP_RDSR2, v2, 1);
    d1 = ~d1 & 8'h7C;
    wr(`SFC_OP_WREN, 16'h0, 0);
    wr(`SFC_OP_WRSR1, {8'h00, d1}, 8);
    repeat (150) @(posedge sys_clk);
    n1 = wm(n1, d1, `SFC_SR1_WMASK, 8'h00);
    v1 = n1;
    rd_stat(`SFC_OP_RDSR1, st(1'b0), 1);
    rd_stat(`SFC_OP_RDSR2, v2, 1);
    wr(`SFC_OP_WREN, 16'h0, 0);
    wr(`SFC_OP_WRSR2, 16'h0, 8);
    repeat (150) @(posedge sys_clk);
    n2 = wm(n2, 8'h00, `SFC_SR2_WMASK, `SFC_SR2_OTP);
    v2 = n2;
    rd_stat(`SFC_OP_RDSR2, v2, 1);
    wr(`SFC_OP_WREN, 16'h0, 0);
    wr(`SFC_OP_WRSR3, 16'h00FF, 8);
    rrd(`SFC_REG_STAT, r);
    chk(r[1:0], 2'b11);
    repeat (150) @(posedge sys_clk);
    rd_stat(`SFC_OP_RDSR2, v2, 1);
    rd_stat(`SFC_OP_RDSR1, st(1'b0), 1);
    wr(`SFC_OP_VWREN, 16'h0, 0);
    wr(`SFC_OP_WRSR1, {8'h00, ~n1 & 8'h7C}, 8);
    pulse(0);
    rd_stat(`SFC_OP_RDSR1, st(1'b0), 1);
    wr(`SFC_OP_WREN, 16'h0, 0);
    pulse(1);
    rrd(`SFC_REG_STAT, r);
    chk(r, {16'h0, v2, st(1'b0)});
    @(posedge sys_clk);
    op_busy <= 1'b1;
    clk_en  <= 1'b0;
    // a frozen block must ignore the read strobe and keep its data at zero
    rrd(`SFC_REG_STAT, r);
    chk(r, 32'h0);
    clk_en <= 1'b1;
    rd_stat(`SFC_OP_RDSR1, st(1'b1), 2);
    host.sel();
    host.tx(`SFC_OP_READ, 8, 1);
    host.tx(32'h0, 24, 1);
    host.rx(1, b);
    chk(io_oe, 4'h0);
    host.desel();
    @(posedge sys_clk);
    op_busy <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      rd_arr(`SFC_OP_READ, k == 0 ? 24'hFFFFFE : 24'($random(seed)), 0, 1, 3);
      rd_arr(`SFC_OP_FREAD, 24'($random(seed)), 8, 1, 2);
      rd_arr(`SFC_OP_DREAD, 24'($random(seed)), 8, 2, 3);
    end
    for (int p = 0; p < 4; p++) begin
      rwr(`SFC_REG_CTRL, 32'(p * 2 + 1));
      rrd(`SFC_REG_CTRL, r);
      chk(r, 32'(p * 2 + 1));
      rd_arr(`SFC_OP_FREAD, 24'($random(seed)), p * 2 + 2, 4, 2);
    end
    // quad_enable must survive a volatile write made in four-wire mode
    host.sel();
    host.tx(`SFC_OP_VWREN, 2, 4);
    host.desel();
    host.sel();
    host.tx(`SFC_OP_WRSR2, 2, 4);
    host.tx(v2 ^ 8'h42, 2, 4);
    host.desel();
    v2 = wm(v2, v2 ^ 8'h42, `SFC_SR2_WMASK & ~`SFC_SR2_QE, `SFC_SR2_OTP);
    rrd(`SFC_REG_STAT, r);
    chk(r[15:8], v2);
    rwr(`SFC_REG_CTRL, 32'h0);
    summarize();
  end
endmodule

// [test/sfc_host.sv]
// host model of the flash link: chip select, serial clock and io lines
// assumes the device finds link edges with its own faster clock
`timescale 1ns/1ps
module sfc_host (
  output logic            spi_cs_n,
  output logic            spi_sck,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  logic [3:0] drv;

  // wire level: the device wins on its enabled lanes
  assign io_in = (io_oe & io_out) | (~io_oe & drv);

  initial begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b0;
    drv      = 4'h5;
  end

  task automatic sel();
    // odd offset keeps link edges off the system clock phase
    #37 spi_cs_n = 1'b0;
    #80;
  endtask

  task automatic desel();
    #80 spi_cs_n = 1'b1;
    drv = ~drv;
    #300;
  endtask

  // n clocks of w lanes, most significant first; sck idles low
  task automatic tx(input logic [31:0] v, input int n, input int w);
    logic [31:0] t;
    for (int i = 0; i < n; i++) begin
      t = v >> ((n - 1 - i) * w);
      drv = (w == 4) ? t[3:0] : {~drv[3:1], t[0]};
      #80 spi_sck = 1'b1;
      #80 spi_sck = 1'b0;
    end
  endtask

  // released lanes toggle each clock so a stale level never looks valid
  task automatic dum(input int n);
    for (int i = 0; i < n; i++) begin
      drv = ~drv;
      #80 spi_sck = 1'b1;
      #80 spi_sck = 1'b0;
    end
  endtask

  task automatic rx(input int w, output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 8 / w; i++) begin
      drv = ~drv;
      #80 spi_sck = 1'b1;
      case (w)
        1: b = {b[6:0], io_in[1]};
        2: b = {b[5:0], io_in[1:0]};
        default: b = {b[3:0], io_in[3:0]};
      endcase
      #80 spi_sck = 1'b0;
    end
  endtask
endmodule
